// >>> src/ppt_pkg.sv
// package: register map, field layout and carriers for the position tracker
package ppt_pkg;
    // ------------------------------------------------------------------
    // channel count and register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int PPT_CH_NUM = 4;
    localparam logic [7:0] PPT_CH_STRIDE = 8'h10;
    localparam logic [3:0] PPT_OFS_POS = 4'h0;
    localparam logic [3:0] PPT_OFS_PRELOAD = 4'h4;
    localparam logic [3:0] PPT_OFS_CTRL = 4'h8;
    localparam logic [7:0] PPT_OFS_INT_STAT = 8'h40;
    localparam logic [7:0] PPT_OFS_INT_MASK = 8'h44;
    localparam logic [7:0] PPT_OFS_DOUT = 8'h48;
    localparam logic [7:0] PPT_OFS_STATE = 8'h4c;
    localparam logic [7:0] PPT_CH_LIMIT = 8'h40;

    // ------------------------------------------------------------------
    // control byte fields
    // ------------------------------------------------------------------
    localparam int PPT_BIT_ESTOP = 7;
    localparam int PPT_BIT_CLEAR = 6;
    localparam int PPT_BIT_LOAD = 4;
    localparam int PPT_BIT_DIR_DIS = 3;

    // ------------------------------------------------------------------
    // interrupt status layout: halts low nibble, rejects high nibble
    // ------------------------------------------------------------------
    localparam int PPT_INT_HALT_LSB = 0;
    localparam int PPT_INT_REJ_LSB = 4;
    localparam int PPT_INT_W = 8;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] PPT_RST_POS = 32'h0000_0000;
    localparam logic [31:0] PPT_RST_PRELOAD = 32'h0000_0000;
    localparam logic [7:0] PPT_RST_INT_MASK = 8'h00;
    localparam logic [3:0] PPT_RST_DOUT = 4'h0;

    typedef struct packed {
        logic estop;
        logic clear;
        logic load;
        logic dir_dis;
    } ppt_ctrl_s;

    localparam ppt_ctrl_s PPT_RST_CTRL = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic [PPT_CH_NUM-1:0] pulse;
        logic [PPT_CH_NUM-1:0] dir;
    } ppt_pins_s;
endpackage

// >>> src/ppt_channel.sv
// one channel: control byte, preload register and position counter
`timescale 1ns/100ps
`default_nettype none
module ppt_channel (
    input wire logic clk,
    input wire logic srst,
    input wire logic ctrl_we,
    input wire logic [7:0] ctrl_wdata,
    input wire logic preload_we,
    input wire logic [31:0] preload_wdata,
    input wire logic halt_cmd,
    input wire logic step_req,
    input wire logic step_dir,
    input wire logic cmd_valid,
    output ppt_pkg::ppt_ctrl_s ctrl,
    output logic [31:0] preload,
    output logic signed [31:0] position,
    output logic step_go,
    output logic cmd_ok,
    output logic cmd_bad
);
    import ppt_pkg::*;

    ppt_ctrl_s next_ctrl;
    logic signed [31:0] next_position;
    logic signed [31:0] step_delta;

    // ------------------------------------------------------------------
    // command gating
    // ------------------------------------------------------------------
    // motion already under way is also frozen while the latch is set
    assign step_go = step_req & ~ctrl.estop;
    assign cmd_ok = cmd_valid & ~ctrl.estop;
    assign cmd_bad = cmd_valid & ctrl.estop;
    assign step_delta = step_dir ? 32'sd1 : -32'sd1;

    // ------------------------------------------------------------------
    // control byte
    // ------------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        if (ctrl_we) begin
            // reserved bits 0..2 and 5 are simply not stored
            next_ctrl.estop = ctrl_wdata[PPT_BIT_ESTOP];
            next_ctrl.clear = ctrl_wdata[PPT_BIT_CLEAR];
            next_ctrl.load = ctrl_wdata[PPT_BIT_LOAD];
            next_ctrl.dir_dis = ctrl_wdata[PPT_BIT_DIR_DIS];
        end
        // a halt in the same cycle as a software clear still latches
        if (halt_cmd) begin
            next_ctrl.estop = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // position counter
    // ------------------------------------------------------------------
    always_comb begin
        if (ctrl.clear) begin
            next_position = '0;
        end else if (ctrl.load) begin
            next_position = signed'(preload);
        end else if (step_go) begin
            next_position = position + step_delta;
        end else begin
            next_position = position;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= PPT_RST_CTRL;
            preload <= PPT_RST_PRELOAD;
            position <= PPT_RST_POS;
        end else begin
            ctrl <= next_ctrl;
            position <= next_position;
            if (preload_we) begin
                preload <= preload_wdata;
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/ppt_top.sv
// top: apb register file, four tracker channels, pins and interrupt
//
// Notes on behaviour
// - each of four pulse channels owns a control byte and a counter
// - signed 32-bit read-only count, +1 forward pulse, -1 reverse pulse
// - per-channel 32-bit preload register, only used when load asks
// - emergency-stop latch set: channel refuses all positioning commands
// - halt command sets the latch; only software writing 0 clears it
// - clear bit set holds the counter at zero
// - load bit set copies the preload into the counter unless the clear bit is also set
// - direction-disable bit hands the direction pin to plain output
`timescale 1ns/100ps
`default_nettype none
module ppt_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] step_req,
    input wire logic [3:0] step_dir,
    input wire logic [3:0] halt_cmd,
    input wire logic [3:0] pos_cmd_valid,
    output ppt_pkg::ppt_pins_s pins,
    output logic [3:0] pos_cmd_accept,
    output logic [3:0] pos_cmd_reject,
    output logic irq
);
    import ppt_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    ppt_ctrl_s ch_ctrl [PPT_CH_NUM];
    logic [31:0] ch_preload [PPT_CH_NUM];
    logic signed [31:0] ch_position [PPT_CH_NUM];
    logic [3:0] ch_step_go;
    logic [3:0] ch_cmd_ok;
    logic [3:0] ch_cmd_bad;
    logic [3:0] ch_dir_dis;
    logic [3:0] ch_estop;
    logic [3:0] ctrl_we;
    logic [3:0] preload_we;

    logic [PPT_INT_W-1:0] int_stat;
    logic [PPT_INT_W-1:0] int_mask;
    logic [PPT_INT_W-1:0] int_event;
    logic [PPT_INT_W-1:0] next_int_stat;
    logic [3:0] dout;
    logic [3:0] last_dir;
    logic [3:0] next_dir;

    // ------------------------------------------------------------------
    // apb phase decode
    // ------------------------------------------------------------------
    // one wait state: pready is registered so every output is a flop
    logic acc_phase;
    logic acc_first;
    logic wr_fire;
    assign acc_phase = psel & penable;
    assign acc_first = acc_phase & ~pready;
    assign wr_fire = acc_phase & pready & pwrite;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic aligned;
    logic ch_space;
    logic [1:0] sel_ch;
    logic [3:0] sel_ofs;
    logic hit_pos;
    logic hit_preload;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_dout;
    logic hit_state;
    logic hit_any;
    logic wr_ro;

    assign aligned = (paddr[1:0] == 2'b00);
    assign ch_space = (paddr < PPT_CH_LIMIT);
    assign sel_ch = paddr[5:4];
    assign sel_ofs = paddr[3:0];
    assign hit_pos = ch_space & (sel_ofs == PPT_OFS_POS);
    assign hit_preload = ch_space & (sel_ofs == PPT_OFS_PRELOAD);
    assign hit_ctrl = ch_space & (sel_ofs == PPT_OFS_CTRL);
    assign hit_stat = (paddr == PPT_OFS_INT_STAT);
    assign hit_mask = (paddr == PPT_OFS_INT_MASK);
    assign hit_dout = (paddr == PPT_OFS_DOUT);
    assign hit_state = (paddr == PPT_OFS_STATE);
    assign hit_any = hit_pos | hit_preload | hit_ctrl | hit_stat
        | hit_mask | hit_dout | hit_state;
    // counter and state words refuse writes with an error
    assign wr_ro = pwrite & (hit_pos | hit_state);

    // ------------------------------------------------------------------
    // channel instances
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PPT_CH_NUM; gi++) begin : g_ch
            assign ctrl_we[gi] = wr_fire & hit_ctrl
                & (sel_ch == 2'(gi));
            assign preload_we[gi] = wr_fire & hit_preload
                & (sel_ch == 2'(gi));
            assign ch_dir_dis[gi] = ch_ctrl[gi].dir_dis;
            assign ch_estop[gi] = ch_ctrl[gi].estop;

            ppt_channel u_channel (
                .clk(clk),
                .srst(srst),
                .ctrl_we(ctrl_we[gi]),
                .ctrl_wdata(pwdata[7:0]),
                .preload_we(preload_we[gi]),
                .preload_wdata(pwdata),
                .halt_cmd(halt_cmd[gi]),
                .step_req(step_req[gi]),
                .step_dir(step_dir[gi]),
                .cmd_valid(pos_cmd_valid[gi]),
                .ctrl(ch_ctrl[gi]),
                .preload(ch_preload[gi]),
                .position(ch_position[gi]),
                .step_go(ch_step_go[gi]),
                .cmd_ok(ch_cmd_ok[gi]),
                .cmd_bad(ch_cmd_bad[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------------
    logic [7:0] ctrl_rd;
    logic [31:0] state_rd;
    logic [31:0] rd_data;

    // reserved control bits are wired to zero on the way out
    assign ctrl_rd = {ch_ctrl[sel_ch].estop, ch_ctrl[sel_ch].clear,
        1'b0, ch_ctrl[sel_ch].load, ch_ctrl[sel_ch].dir_dis,
        3'b000};
    assign state_rd = {20'h0_0000, last_dir, ch_dir_dis, ch_estop};
    assign rd_data = hit_pos ? ch_position[sel_ch]
        : hit_preload ? ch_preload[sel_ch]
        : hit_ctrl ? {24'h00_0000, ctrl_rd}
        : hit_stat ? {24'h00_0000, int_stat}
        : hit_mask ? {24'h00_0000, int_mask}
        : hit_dout ? {28'h000_0000, dout}
        : hit_state ? state_rd
        : 32'h0000_0000;

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    logic bad_access;
    assign bad_access = ~aligned | ~hit_any | wr_ro;

    always_ff @(posedge clk) begin
        if (srst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (acc_first) begin
            pready <= 1'b1;
            prdata <= (pwrite | bad_access) ? 32'h0000_0000 : rd_data;
            pslverr <= bad_access;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // software registers outside the channels
    // ------------------------------------------------------------------
    logic mask_we;
    logic dout_we;
    logic stat_we;
    logic wr_ok;
    assign wr_ok = wr_fire & aligned & ~wr_ro;
    assign mask_we = wr_ok & hit_mask;
    assign dout_we = wr_ok & hit_dout;
    assign stat_we = wr_ok & hit_stat;

    always_ff @(posedge clk) begin
        if (srst) begin
            int_mask <= PPT_RST_INT_MASK;
            dout <= PPT_RST_DOUT;
        end else begin
            if (mask_we) begin
                int_mask <= pwdata[PPT_INT_W-1:0];
            end
            if (dout_we) begin
                dout <= pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    // a new event beats a write-one clear in the same cycle
    assign int_event = {ch_cmd_bad, halt_cmd};
    assign next_int_stat = (int_stat
        & ~(stat_we ? pwdata[PPT_INT_W-1:0] : 8'h00)) | int_event;

    always_ff @(posedge clk) begin
        if (srst) begin
            int_stat <= '0;
            irq <= 1'b0;
        end else begin
            int_stat <= next_int_stat;
            irq <= |(next_int_stat & int_mask);
        end
    end

    // ------------------------------------------------------------------
    // pins and command answers
    // ------------------------------------------------------------------
    // direction keeps its last level between pulses so the drive sees
    // a stable setup before the next edge
    assign next_dir = (step_req & step_dir) | (~step_req & last_dir);

    always_ff @(posedge clk) begin
        if (srst) begin
            pins <= '0;
            last_dir <= 4'h0;
            pos_cmd_accept <= 4'h0;
            pos_cmd_reject <= 4'h0;
        end else begin
            last_dir <= next_dir;
            pins.pulse <= ch_step_go;
            // disabled direction output becomes a plain output pin
            pins.dir <= (ch_dir_dis & dout)
                | (~ch_dir_dis & next_dir);
            pos_cmd_accept <= ch_cmd_ok;
            pos_cmd_reject <= ch_cmd_bad;
        end
    end
endmodule
`default_nettype wire

// >>> dv/ppt_drive_model.sv
// drive model: counts the pulses it receives, by direction, per channel
`timescale 1ns/100ps
`default_nettype none
module ppt_drive_model (
    input wire logic clk,
    input wire logic srst,
    input wire ppt_pkg::ppt_pins_s pins,
    output logic signed [31:0] drive_pos [4]
);
    import ppt_pkg::*;
    // ------------------------------------------------------------------
    // the drive latches the direction level with each pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (srst) begin
                drive_pos[i] <= '0;
            end else if (pins.pulse[i]) begin
                drive_pos[i] <= drive_pos[i]
                    + (pins.dir[i] ? 1 : -1);
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/ppt_top_properties.sv
// checker: bus timing and channel properties of the tracker top
`timescale 1ns/100ps
`default_nettype none
module ppt_top_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] step_req,
    input wire logic [3:0] halt_cmd,
    input wire logic [3:0] pos_cmd_valid,
    input wire ppt_pkg::ppt_pins_s pins,
    input wire logic [3:0] pos_cmd_accept,
    input wire logic [3:0] pos_cmd_reject
);
    import ppt_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    wire acc = psel && penable && !pready;
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_ready_wait: assert property (acc |=> pready)
        else $error("no answer after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_pos_readonly: assert property (
        acc && pwrite && paddr == 8'h00 |=> pslverr)
        else $error("position write not refused");
    a_pulse_cause: assert property (
        (pins.pulse & ~$past(step_req)) == 4'h0)
        else $error("pulse without request");
    a_cmd_answer: assert property (
        (pos_cmd_accept | pos_cmd_reject) == $past(pos_cmd_valid))
        else $error("command answer mismatch");
    a_cmd_exclusive: assert property (
        (pos_cmd_accept & pos_cmd_reject) == 4'h0)
        else $error("accept and reject together");
    a_halt_blocks: assert property (
        halt_cmd[3] ##1 step_req[3] |=> !pins.pulse[3])
        else $error("step after halt");
    a_halt_rejects: assert property (
        halt_cmd[3] ##1 pos_cmd_valid[3] |=> pos_cmd_reject[3])
        else $error("command after halt not refused");
    c_err: cover property (pslverr);
    c_rej: cover property (pos_cmd_reject[3]);
    c_pulse: cover property (pins.pulse[1]);
endmodule
bind ppt_top ppt_top_checker ppt_top_checker_inst (.clk(clk), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .step_req(step_req),
    .halt_cmd(halt_cmd), .pos_cmd_valid(pos_cmd_valid), .pins(pins),
    .pos_cmd_accept(pos_cmd_accept), .pos_cmd_reject(pos_cmd_reject));
`default_nettype wire

// >>> dv/ppt_top_bench.sv
// testbench: register and channel sequences for the tracker top
`timescale 1ns/100ps
`default_nettype none
module ppt_top_bench;
    import ppt_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, err;
    logic [3:0] step_req = 4'h0, step_dir = 4'h0, halt_cmd = 4'h0;
    logic [3:0] pos_cmd_valid = 4'h0, pos_cmd_accept, pos_cmd_reject;
    ppt_pins_s pins;
    logic signed [31:0] drive_pos [4];
    int error_cnt = 0, checks_done = 0;
    always #12.5 clk = ~clk;
    ppt_top ppt_top_inst (.clk(clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .step_req(step_req), .step_dir(step_dir), .halt_cmd(halt_cmd),
        .pos_cmd_valid(pos_cmd_valid), .pins(pins),
        .pos_cmd_accept(pos_cmd_accept), .pos_cmd_reject(pos_cmd_reject),
        .irq(irq));
    ppt_drive_model ppt_drive_model_inst (.clk(clk), .srst(srst),
        .pins(pins), .drive_pos(drive_pos));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; an idle edge after it keeps drivers apart
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic e);
        xfer(a, 1'b1, d);
        chk({31'h0, err}, {31'h0, e});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic steps(input int ch, input logic d, input int cnt);
        repeat (cnt) begin
            step_req[ch] <= 1'b1;
            step_dir[ch] <= d;
            @(posedge clk);
        end
        step_req[ch] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [7:0] ra(input int ch, input logic [3:0] o);
        return {ch[3:0], o};
    endfunction
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            rchk(ra(c, PPT_OFS_CTRL), 32'h0);
            wr(ra(c, PPT_OFS_PRELOAD), 32'h1234_5670 + c, 1'b0);
            rchk(ra(c, PPT_OFS_PRELOAD), 32'h1234_5670 + c);
            wr(ra(c, PPT_OFS_POS), 32'h5, 1'b1);
            rchk(ra(c, PPT_OFS_POS), PPT_RST_POS);
            wr(ra(c, PPT_OFS_CTRL), 32'h27, 1'b0);
            rchk(ra(c, PPT_OFS_CTRL), 32'h0);
        end
        steps(1, 1'b1, 5);
        rchk(ra(1, PPT_OFS_POS), 32'h5);
        steps(1, 1'b0, 7);
        rchk(ra(1, PPT_OFS_POS), 32'hffff_fffe);
        chk(drive_pos[1], 32'hffff_fffe);
        wr(ra(1, PPT_OFS_CTRL), 32'h10, 1'b0);
        wr(ra(1, PPT_OFS_CTRL), 32'h0, 1'b0);
        steps(1, 1'b1, 1);
        rchk(ra(1, PPT_OFS_POS), 32'h1234_5672);
        wr(ra(1, PPT_OFS_CTRL), 32'h50, 1'b0);
        steps(1, 1'b1, 2);
        rchk(ra(1, PPT_OFS_CTRL), 32'h50);
        rchk(ra(1, PPT_OFS_POS), 32'h0);
        wr(PPT_OFS_DOUT, 32'h4, 1'b0);
        wr(ra(2, PPT_OFS_CTRL), 32'h08, 1'b0);
        steps(2, 1'b0, 1);
        chk({31'h0, pins.dir[2]}, 32'h1);
        wr(ra(2, PPT_OFS_CTRL), 32'h0, 1'b0);
        // the pin flop only sees the cleared bit one edge after the write
        @(posedge clk);
        chk({31'h0, pins.dir[2]}, 32'h0);
        wr(PPT_OFS_INT_MASK, 32'h88, 1'b0);
        halt_cmd[3] <= 1'b1;
        @(posedge clk);
        halt_cmd[3] <= 1'b0;
        step_req[3] <= 1'b1;
        pos_cmd_valid[3] <= 1'b1;
        @(posedge clk);
        step_req[3] <= 1'b0;
        pos_cmd_valid[3] <= 1'b0;
        @(posedge clk);
        chk({28'h0, pos_cmd_reject}, 32'h8);
        chk({31'h0, irq}, 32'h1);
        rchk(ra(3, PPT_OFS_CTRL), 32'h80);
        rchk(ra(3, PPT_OFS_POS), 32'h0);
        rchk(PPT_OFS_INT_STAT, 32'h88);
        wr(PPT_OFS_INT_STAT, 32'h88, 1'b0);
        rchk(PPT_OFS_INT_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(ra(3, PPT_OFS_CTRL), 32'h0, 1'b0);
        steps(3, 1'b1, 1);
        rchk(ra(3, PPT_OFS_POS), 32'h1);
        pos_cmd_valid[3] <= 1'b1;
        @(posedge clk);
        pos_cmd_valid[3] <= 1'b0;
        @(posedge clk);
        chk({24'h0, pos_cmd_accept, pos_cmd_reject}, 32'h80);
        xfer(8'h50, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
